// ===== bench/fmt_decode_sva.sv
// Checker for the instruction format decoder, bound to its top ports.
// Assumes the result register answers one mclk edge after sampling.
`timescale 1ns/1ps
`include "fmt_decode_params.svh"
module fmt_decode_sva
    import fmt_decode_pkg::*;
(
    input wire logic                 mclk,
    input wire logic                 sys_rst,
    input wire logic                 insn_valid,
    input wire logic [`INSN_W-1:0]   insn,
    input wire fmt_decode_pkg::dec_t dec_out
);
    // ********************
    // Clocking and steps
    // ********************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // Valid word whose top nibble selects a format
    sequence s_take(logic [3:0] nib);
        insn_valid && insn[15:12] == nib;
    endsequence

    // ********************
    // Assertions
    // ********************
    a_reset_clears: assert property ($fell(sys_rst) |-> dec_out == '0)
        else $error("result not cleared by reset");
    a_valid_gate: assert property (!insn_valid |=> !dec_out.valid)
        else $error("valid without a presented word");
    a_bad_invalid: assert property (dec_out.fmt == FMT_BAD |-> !dec_out.valid)
        else $error("unmatched word flagged valid");
    a_zero_nop: assert property (insn_valid && insn == 16'h0009 |=> dec_out.fmt == FMT_ZERO && dec_out.valid)
        else $error("no-operand word misclassified");
    a_ni_fields: assert property (s_take(4'h7) |=> dec_out.fmt == FMT_NI &&
        dec_out.dest_reg_field == $past(insn[11:8]) && dec_out.imm_val == {{24{$past(insn[7])}}, $past(insn[7:0])})
        else $error("register immediate fields wrong");
    a_nmd_fields: assert property (insn_valid && insn[15:12] inside {4'h1, 4'h5} |=>
        dec_out.fmt == FMT_NMD && dec_out.dest_reg_field == $past(insn[11:8]) &&
        dec_out.src_reg_field == $past(insn[7:4]) && dec_out.disp_off == {26'h0, $past(insn[3:0]), 2'h0})
        else $error("two register displacement fields wrong");
    a_bra_disp: assert property (s_take(4'hA) |=> dec_out.fmt == FMT_D12 &&
        dec_out.disp_off == {{19{$past(insn[11])}}, $past(insn[11:0]), 1'b0})
        else $error("long branch offset wrong");
    a_trap_imm: assert property (insn_valid && insn[15:8] == 8'hC3 |=> dec_out.src_mode == AM_TRAP &&
        dec_out.imm_val == {22'h0, $past(insn[7:0]), 2'h0})
        else $error("trap number wrong");
    a_pc_long: assert property (s_take(4'hD) |=> dec_out.fmt == FMT_ND8 && dec_out.pc_align &&
        dec_out.dest_reg_field == $past(insn[11:8]) && dec_out.disp_off == {22'h0, $past(insn[7:0]), 2'h0})
        else $error("long pc relative load wrong");
    a_mac_pair: assert property (insn_valid && insn[15:12] == 4'h4 && insn[3:0] == 4'hF |=>
        dec_out.src_mode == AM_POSTINC && dec_out.dst_mode == AM_MAC_PAIR)
        else $error("multiply accumulate roles wrong");
endmodule

// ===== bench/tb.sv
// Bench for the instruction format decoder: directed and random words.
// Assumes the rtl package and header compile first; binds the checker.
`timescale 1ns/1ps
`include "fmt_decode_params.svh"
module tb;
    import fmt_decode_pkg::*;
    // ********************
    // Signals
    // ********************
    logic               mclk;        // Core clock, 4 ns
    logic               sys_rst;     // Reset, high
    logic               insn_valid;  // Word present
    logic [`INSN_W-1:0] insn;        // Word driven
    dec_t               dec_out;     // Decoder result
    logic               sent;        // Word launched at this edge
    logic               seen_q;      // Its result now settled
    int                 err_total;   // Mismatches
    int                 check_count; // Comparisons
    dec_t               exp_q[$];    // Expected results, oldest first
    dec_t               msk_q[$];    // Fields that count per result

    instruction_format_decoder instruction_format_decoder_i (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .insn_valid (insn_valid),
        .insn       (insn),
        .dec_out    (dec_out)
    );

    // Free running clock
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Masked compare; an unknown in a kept bit fails
    task automatic cmp(input dec_t e, input dec_t m);
        check_count++;
        if (((dec_out ^ e) & m) !== '0)
        begin
            err_total++;
            $display("Error dec_out expected %h seen %h", e, dec_out);
        end
    endtask

    // Launch one word; sel picks dr,sr,dsp,imm,pa,sm,dm from bit 6 down
    task automatic snd(input logic [15:0] w, input fmt_t f, input logic [6:0] sel, input logic [3:0] dr,
                       input logic [3:0] sr, input logic [31:0] dsp, input logic [31:0] imm, input logic pa,
                       input amode_t sm, input amode_t dm, input logic v = 1'b1);
        @(posedge mclk);
        insn       <= w;
        insn_valid <= v;
        sent       <= 1'b1;
        exp_q.push_back({v && f != FMT_BAD, f, sm, dm, dr, sr, dsp, pa, imm});
        msk_q.push_back({1'b1, 4'hF, {4{sel[1]}}, {4{sel[0]}}, {4{sel[6]}}, {4{sel[5]}}, {32{sel[4]}},
                         sel[2], {32{sel[3]}}});
    endtask

    // Verdict, reached from the main sequence or the watchdog
    task automatic complete_run();
        $display("Checks %0d, errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Result lands one edge after the word is launched
    always @(posedge mclk)
        seen_q <= sent;

    // Low phase: outputs settled, oldest note taken
    always @(negedge mclk)
    begin
        if (seen_q)
        begin
            if (exp_q.size() == 0)
            begin
                err_total++;
                $display("Error dec_out expected none seen %h", dec_out);
            end
            else
                cmp(exp_q.pop_front(), msk_q.pop_front());
        end
    end

    // Watchdog, well past the planned run length
    initial
    begin
        repeat (3000) @(posedge mclk);
        err_total++;
        complete_run();
    end

    // ********************
    // Main sequence
    // ********************
    initial
    begin
        logic [3:0] n;
        logic [3:0] r;
        logic [3:0] d;
        logic [7:0] i;
        sys_rst     = 1'b1;
        insn_valid  = 1'b0;
        insn        = '0;
        sent        = 1'b0;
        err_total   = 0;
        check_count = 0;
        n = 4'($urandom(32'h35F5));
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        @(negedge mclk);
        cmp('0, '1);
        // Directed words, back to back
        snd(16'h0009, FMT_ZERO, 7'h03, 0, 0, 0, 0, 0, AM_NONE, AM_NONE);
        snd(16'h0000, FMT_BAD, 7'h00, 0, 0, 0, 0, 0, AM_NONE, AM_NONE);
        snd(16'hF000, FMT_BAD, 7'h00, 0, 0, 0, 0, 0, AM_NONE, AM_NONE);
        snd(16'h0529, FMT_N, 7'h43, 4'h5, 0, 0, 0, 0, AM_NONE, AM_REG);
        snd(16'h4703, FMT_N, 7'h43, 4'h7, 0, 0, 0, 0, AM_CTRL_SYS, AM_PREDEC);
        snd(16'h4A07, FMT_M, 7'h23, 0, 4'hA, 0, 0, 0, AM_POSTINC, AM_CTRL_SYS);
        snd(16'h4B0B, FMT_M, 7'h20, 0, 4'hB, 0, 0, 0, AM_NONE, AM_NONE);
        snd(16'h461F, FMT_NM, 7'h63, 4'h6, 4'h1, 0, 0, 0, AM_POSTINC, AM_MAC_PAIR);
        snd(16'h6386, FMT_NM, 7'h63, 4'h3, 4'h8, 0, 0, 0, AM_POSTINC, AM_REG);
        snd(16'h2B46, FMT_NM, 7'h63, 4'hB, 4'h4, 0, 0, 0, AM_REG, AM_PREDEC);
        snd(16'h0C56, FMT_NM, 7'h63, 4'hC, 4'h5, 0, 0, 0, AM_REG, AM_IDX_R0);
        snd(16'h84A7, FMT_MD, 7'h32, 0, 4'hA, 32'h7, 0, 0, AM_DISP_REG, AM_NONE);
        snd(16'h813F, FMT_ND4, 7'h51, 4'h3, 0, 32'h1E, 0, 0, AM_NONE, AM_DISP_REG);
        snd(16'hC4FF, FMT_D, 7'h16, 0, 0, 32'hFF, 0, 0, AM_DISP_GBR, AM_NONE);
        snd(16'hC780, FMT_D, 7'h16, 0, 0, 32'h200, 0, 1, AM_PC_DISP, AM_NONE);
        snd(16'h8B80, FMT_D, 7'h12, 0, 0, 32'hFFFFFF00, 0, 0, AM_PC_BRANCH, AM_NONE);
        snd(16'h92FF, FMT_ND8, 7'h54, 4'h2, 0, 32'h1FE, 0, 0, AM_NONE, AM_NONE);
        snd(16'hD4FF, FMT_ND8, 7'h54, 4'h4, 0, 32'h3FC, 0, 1, AM_NONE, AM_NONE);
        snd(16'hCD81, FMT_I, 7'h09, 0, 0, 0, 32'h81, 0, AM_NONE, AM_IDX_GBR);
        snd(16'h88FE, FMT_I, 7'h08, 0, 0, 0, 32'hFFFFFFFE, 0, AM_NONE, AM_NONE);
        snd(16'hC8FE, FMT_I, 7'h08, 0, 0, 0, 32'hFE, 0, AM_NONE, AM_NONE);
        // Random fields; presence flag random on the register pair word
        repeat (12)
        begin
            n = 4'($urandom());
            r = 4'($urandom());
            d = 4'($urandom());
            i = 8'($urandom());
            snd({4'h7, n, i}, FMT_NI, 7'h48, n, 0, 0, {{24{i[7]}}, i}, 0, AM_NONE, AM_NONE);
            snd({(i[0] ? 4'h1 : 4'h5), n, r, d}, FMT_NMD, 7'h70, n, r, {26'h0, d, 2'h0}, 0, 0, AM_NONE, AM_NONE);
            snd({4'hA, n, i}, FMT_D12, 7'h10, 0, 0, {{19{n[3]}}, n, i, 1'b0}, 0, 0, AM_NONE, AM_NONE);
            snd({8'hC3, i}, FMT_I, 7'h0A, 0, 0, 0, {22'h0, i, 2'h0}, 0, AM_TRAP, AM_NONE);
            snd({4'h3, n, r, 4'hC}, FMT_NM, 7'h63, n, r, 0, 0, 0, AM_REG, AM_REG, 1'($urandom()));
        end
        // Reset in mid run, right behind a word
        snd(16'h7F80, FMT_NI, 7'h48, 4'hF, 0, 0, 32'hFFFFFF80, 0, AM_NONE, AM_NONE);
        @(posedge mclk);
        sent       <= 1'b0;
        insn_valid <= 1'b0;
        sys_rst    <= 1'b1;
        @(negedge mclk);
        @(negedge mclk);
        cmp('0, '1);
        @(posedge mclk);
        sys_rst <= 1'b0;
        snd(16'h0009, FMT_ZERO, 7'h03, 0, 0, 0, 0, 0, AM_NONE, AM_NONE);
        @(posedge mclk);
        sent       <= 1'b0;
        insn_valid <= 1'b0;
        repeat (3) @(posedge mclk);
        complete_run();
    end
endmodule

bind instruction_format_decoder fmt_decode_sva fmt_decode_sva_i (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .insn_valid (insn_valid),
    .insn       (insn),
    .dec_out    (dec_out)
);

// ===== rtl/fmt_decode_params.svh
// Constants for the instruction format decoder: field positions and widths.
// Assumes a 16-bit instruction word; included by the package, the checker and the bench.
`ifndef FMT_DECODE_PARAMS_SVH
`define FMT_DECODE_PARAMS_SVH
`define INSN_W       16
`define REG_HI_MSB   11
`define REG_HI_LSB   8
`define REG_LO_MSB   7
`define REG_LO_LSB   4
`define DISP4_MSB    3
`define DISP8_MSB    7
`define DISP12_MSB   11
`define IMM8_MSB     7
`define R0_NUM       4'h0
`endif

// ===== rtl/fmt_decode_pkg.sv
// Types shared by the format decoder and whoever consumes its result.
// Assumes fmt_decode_params.svh is on the include path.
`include "fmt_decode_params.svh"
package fmt_decode_pkg;
    // Operand formats
    typedef enum logic [3:0] {
        FMT_ZERO, FMT_N, FMT_M, FMT_NM, FMT_MD, FMT_ND4, FMT_NMD,
        FMT_D, FMT_D12, FMT_ND8, FMT_I, FMT_NI, FMT_BAD
    } fmt_t;
    // Addressing role of an operand
    typedef enum logic [3:0] {
        AM_NONE, AM_REG, AM_POSTINC, AM_PREDEC, AM_IDX_R0, AM_DISP_REG,
        AM_DISP_GBR, AM_IDX_GBR, AM_PC_DISP, AM_PC_BRANCH, AM_CTRL_SYS,
        AM_MAC_PAIR, AM_IMM, AM_TRAP
    } amode_t;
    // Access size for displacement scaling
    typedef enum logic [1:0] {SZ_B, SZ_W, SZ_L} size_t;
    // Decoded result
    typedef struct packed {
        logic        valid;
        fmt_t        fmt;
        amode_t      src_mode;
        amode_t      dst_mode;
        logic [3:0]  dest_reg_field;
        logic [3:0]  src_reg_field;
        logic [31:0] disp_off;   // Scaled or doubled offset
        logic        pc_align;   // Clear program_counter low two bits first
        logic [31:0] imm_val;    // Extended immediate
    } dec_t;
endpackage

// ===== rtl/instruction_format_decoder.sv
// Instruction format decoder: classifies a 16-bit word, extracts fields.
// Assumes the fetch stage presents insn with insn_valid on the mclk domain.
//
// Summary of operation
// - Each field letter decoded distinctly by opcode
// - n format: bits 11-8 destination register
// - m format: bits 11-8 source register
// - nm format: destination 11-8, source 7-4
// - multiply accumulate: post-increment source, mac pair target
// - md format: base 7-4 disp source, r0 dest
// - nd4 format: r0 source, base+disp destination
// - nmd format: n, m, displacement fields
// - d format: 8-bit gbr, pc or branch displacement
// - d12 format: 12-bit unconditional branch offset
// - nd8 format: pc-relative load into destination
// - i format: immediate with gbr, r0, trap
// - ni format: immediate applied to destination register
// - Base displacements zero-extended, scaled 1/2/4
// - Long pc-relative data clears pc low bits
// - Branch displacements sign-extended and doubled
// - Immediates zero/sign extended, trap times four
`timescale 1ns/1ps
module instruction_format_decoder
    import fmt_decode_pkg::*;
(
    input  wire logic                  mclk,       // Core clock, 250 MHz
    input  wire logic                  sys_rst,    // Synchronous reset, high
    input  wire logic                  insn_valid, // Word present this cycle
    input  wire logic [`INSN_W-1:0]    insn,       // Instruction word
    output fmt_decode_pkg::dec_t       dec_out     // Registered decode result
);
    import fmt_decode_pkg::*;

    // ************************************************************
    // Decode state
    // ************************************************************
    dec_t dec_q;  // Registered result
    dec_t dec_d;  // Next result

    logic [3:0] hi_nib;   // Bits 15-12
    logic [3:0] lo_nib;   // Bits 3-0
    logic [7:0] lo_byte;  // Bits 7-0
    logic [3:0] f_n;      // Bits 11-8
    logic [3:0] f_m;      // Bits 7-4
    logic [7:0] f_d8;     // Eight-bit displacement / immediate
    logic [11:0] f_d12;   // Twelve-bit displacement

    assign hi_nib  = insn[15:12];
    assign lo_nib  = insn[`DISP4_MSB:0];
    assign lo_byte = insn[`DISP8_MSB:0];
    assign f_n     = insn[`REG_HI_MSB:`REG_HI_LSB];
    assign f_m     = insn[`REG_LO_MSB:`REG_LO_LSB];
    assign f_d8    = insn[`DISP8_MSB:0];
    assign f_d12   = insn[`DISP12_MSB:0];

    // ************************************************************
    // Extension helpers
    // ************************************************************
    // Zero-extend then scale by access size
    function automatic logic [31:0] zscale(input logic [7:0] d, input size_t s);
        logic [31:0] z;
        z = {24'h000000, d};
        case (s)
            SZ_W:    zscale = {z[30:0], 1'b0};
            SZ_L:    zscale = {z[29:0], 2'b00};
            default: zscale = z;
        endcase
    endfunction

    // ************************************************************
    // Field extraction and classification
    // ************************************************************
    // Unmatched words under nibbles 0 and 8 flag illegal, nibble F always; the other nibbles accept any word.
    always_comb
    begin
        dec_d = '0;
        dec_d.fmt = FMT_BAD;
        dec_d.src_mode = AM_NONE;
        dec_d.dst_mode = AM_NONE;
        case (hi_nib)
            4'h0:
            begin
                if (insn == 16'h0009 || insn == 16'h0008 || insn == 16'h000B ||
                    insn == 16'h0018 || insn == 16'h0028 || insn == 16'h0019 ||
                    insn == 16'h002B || insn == 16'h001B)
                begin
                    dec_d.fmt = FMT_ZERO;  // No operand fields
                end
                else if (lo_byte == 8'h29 || lo_byte == 8'h0A || lo_byte == 8'h1A ||
                         lo_byte == 8'h2A || lo_byte == 8'h02 || lo_byte == 8'h12 ||
                         lo_byte == 8'h22)
                begin
                    dec_d.fmt = FMT_N;
                    dec_d.dest_reg_field = f_n;
                    dec_d.dst_mode = AM_REG;
                    dec_d.src_mode = (lo_byte == 8'h29) ? AM_NONE : AM_CTRL_SYS;
                end
                else if (lo_byte == 8'h23 || lo_byte == 8'h03)
                begin
                    dec_d.fmt = FMT_M;  // Branch far through register
                    dec_d.src_reg_field = f_n;
                    dec_d.src_mode = AM_REG;
                end
                else if (lo_nib == 4'hF)
                begin
                    dec_d.fmt = FMT_NM;  // Multiply accumulate
                    dec_d.dest_reg_field = f_n;
                    dec_d.src_reg_field = f_m;
                    dec_d.src_mode = AM_POSTINC;
                    dec_d.dst_mode = AM_MAC_PAIR;
                end
                else if (lo_nib inside {4'h4, 4'h5, 4'h6})
                begin
                    dec_d.fmt = FMT_NM;  // Store indexed by r0
                    dec_d.dest_reg_field = f_n;
                    dec_d.src_reg_field = f_m;
                    dec_d.src_mode = AM_REG;
                    dec_d.dst_mode = AM_IDX_R0;
                end
                else if (lo_nib inside {4'hC, 4'hD, 4'hE})
                begin
                    dec_d.fmt = FMT_NM;  // Load indexed by r0
                    dec_d.dest_reg_field = f_n;
                    dec_d.src_reg_field = f_m;
                    dec_d.src_mode = AM_IDX_R0;
                    dec_d.dst_mode = AM_REG;
                end
            end
            4'h1:
            begin
                dec_d.fmt = FMT_NMD;  // Store with displacement
                dec_d.dest_reg_field = f_n;
                dec_d.src_reg_field = f_m;
                dec_d.src_mode = AM_REG;
                dec_d.dst_mode = AM_DISP_REG;
                dec_d.disp_off = zscale({4'h0, lo_nib}, SZ_L);
            end
            4'h5:
            begin
                dec_d.fmt = FMT_NMD;  // Load with displacement
                dec_d.dest_reg_field = f_n;
                dec_d.src_reg_field = f_m;
                dec_d.src_mode = AM_DISP_REG;
                dec_d.dst_mode = AM_REG;
                dec_d.disp_off = zscale({4'h0, lo_nib}, SZ_L);
            end
            4'h2, 4'h3, 4'h6:
            begin
                dec_d.fmt = FMT_NM;
                dec_d.dest_reg_field = f_n;
                dec_d.src_reg_field = f_m;
                dec_d.src_mode = AM_REG;
                dec_d.dst_mode = AM_REG;
                if (hi_nib == 4'h2 && lo_nib inside {4'h4, 4'h5, 4'h6})
                    dec_d.dst_mode = AM_PREDEC;
                else if (hi_nib == 4'h2 && lo_nib inside {4'h0, 4'h1, 4'h2})
                    dec_d.dst_mode = AM_REG;  // Register-indirect store
                else if (hi_nib == 4'h6 && lo_nib inside {4'h4, 4'h5, 4'h6})
                    dec_d.src_mode = AM_POSTINC;
            end
            4'h4:
            begin
                if (lo_nib == 4'hF)
                begin
                    dec_d.fmt = FMT_NM;  // Word multiply accumulate
                    dec_d.dest_reg_field = f_n;
                    dec_d.src_reg_field = f_m;
                    dec_d.src_mode = AM_POSTINC;
                    dec_d.dst_mode = AM_MAC_PAIR;
                end
                else if (lo_nib == 4'h2 || lo_nib == 4'h3)
                begin
                    dec_d.fmt = FMT_N;  // Store control to pre-decrement
                    dec_d.dest_reg_field = f_n;
                    dec_d.src_mode = AM_CTRL_SYS;
                    dec_d.dst_mode = AM_PREDEC;
                end
                else if (lo_nib == 4'h6 || lo_nib == 4'h7 || lo_nib == 4'hA ||
                         lo_nib == 4'hE || lo_byte == 8'h2B || lo_byte == 8'h0B)
                begin
                    dec_d.fmt = FMT_M;
                    dec_d.src_reg_field = f_n;
                    dec_d.src_mode = (lo_nib inside {4'h6, 4'h7}) ? AM_POSTINC : AM_REG;
                    dec_d.dst_mode = (lo_nib == 4'hB) ? AM_NONE : AM_CTRL_SYS;
                end
                else
                begin
                    dec_d.fmt = FMT_N;  // Shifts and single-register ops
                    dec_d.dest_reg_field = f_n;
                    dec_d.dst_mode = AM_REG;
                end
            end
            4'h7:
            begin
                dec_d.fmt = FMT_NI;  // Sign-extended add
                dec_d.dest_reg_field = f_n;
                dec_d.src_mode = AM_IMM;
                dec_d.dst_mode = AM_REG;
                dec_d.imm_val = {{24{f_d8[7]}}, f_d8};
            end
            4'h8:
            begin
                if (f_n[3:1] == 3'b000 || f_n[3:1] == 3'b010)
                begin
                    dec_d.fmt = (f_n[2]) ? FMT_MD : FMT_ND4;
                    dec_d.src_reg_field = f_n[2] ? f_m : `R0_NUM;
                    dec_d.dest_reg_field = f_n[2] ? `R0_NUM : f_m;
                    dec_d.src_mode = f_n[2] ? AM_DISP_REG : AM_REG;
                    dec_d.dst_mode = f_n[2] ? AM_REG : AM_DISP_REG;
                    dec_d.disp_off = zscale({4'h0, lo_nib}, f_n[0] ? SZ_W : SZ_B);
                end
                else if (f_n == 4'h8)
                begin
                    dec_d.fmt = FMT_I;  // Equality compare, sign-extended
                    dec_d.src_mode = AM_IMM;
                    dec_d.dst_mode = AM_REG;
                    dec_d.imm_val = {{24{f_d8[7]}}, f_d8};
                end
                else if (f_n == 4'h9 || f_n == 4'hB)
                begin
                    dec_d.fmt = FMT_D;  // Conditional branch
                    dec_d.src_mode = AM_PC_BRANCH;
                    dec_d.disp_off = {{23{f_d8[7]}}, f_d8, 1'b0};
                end
            end
            4'hA, 4'hB:
            begin
                dec_d.fmt = FMT_D12;  // Unconditional branch
                dec_d.src_mode = AM_PC_BRANCH;
                dec_d.disp_off = {{19{f_d12[11]}}, f_d12, 1'b0};
            end
            4'h9, 4'hD:
            begin
                dec_d.fmt = FMT_ND8;
                dec_d.dest_reg_field = f_n;
                dec_d.src_mode = AM_PC_DISP;
                dec_d.dst_mode = AM_REG;
                dec_d.pc_align = (hi_nib == 4'hD);
                dec_d.disp_off = zscale(f_d8, (hi_nib == 4'hD) ? SZ_L : SZ_W);
            end
            4'hE:
            begin
                dec_d.fmt = FMT_NI;  // Sign-extended move
                dec_d.dest_reg_field = f_n;
                dec_d.src_mode = AM_IMM;
                dec_d.dst_mode = AM_REG;
                dec_d.imm_val = {{24{f_d8[7]}}, f_d8};
            end
            4'hC:
            begin
                dec_d.src_reg_field = `R0_NUM;
                dec_d.dest_reg_field = `R0_NUM;
                if (f_n[3:2] == 2'b00)
                begin
                    dec_d.fmt = FMT_D;  // Gbr-relative transfer
                    dec_d.src_mode = f_n[3] ? AM_DISP_GBR : (f_n == 4'h3 ? AM_TRAP : AM_REG);
                    dec_d.dst_mode = AM_DISP_GBR;
                    dec_d.disp_off = zscale(f_d8, size_t'(f_n[1:0]));
                    if (f_n == 4'h3)
                    begin
                        dec_d.fmt = FMT_I;  // Trap number times four
                        dec_d.dst_mode = AM_NONE;
                        dec_d.disp_off = '0;
                        dec_d.imm_val = zscale(f_d8, SZ_L);
                    end
                end
                else if (f_n[3:2] == 2'b01)
                begin
                    dec_d.fmt = FMT_D;
                    dec_d.src_mode = AM_DISP_GBR;
                    dec_d.dst_mode = AM_REG;
                    dec_d.disp_off = zscale(f_d8, size_t'(f_n[1:0]));
                    if (f_n == 4'h7)
                    begin
                        dec_d.src_mode = AM_PC_DISP;  // Address generation into r0
                        dec_d.pc_align = 1'b1;
                        dec_d.disp_off = zscale(f_d8, SZ_L);
                    end
                end
                else
                begin
                    dec_d.fmt = FMT_I;  // Logic with zero-extended imm
                    dec_d.src_mode = AM_IMM;
                    dec_d.dst_mode = f_n[2] ? AM_IDX_GBR : AM_REG;
                    dec_d.imm_val = {24'h000000, f_d8};
                end
            end
            default:
            begin
                dec_d.fmt = FMT_BAD;
            end
        endcase
        dec_d.valid = insn_valid && (dec_d.fmt != FMT_BAD);
    end

    // ************************************************************
    // Result register
    // ************************************************************
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            dec_q <= '0;
        else
            dec_q <= dec_d;
    end

    assign dec_out = dec_q;
endmodule
